/* rtl/idc_illum_ctrl.sv */
// What this block does
// - Polarity bit 1 inverts both illumination outputs while drivers are enabled.
// - Primary driver conducts only while its select bit is 1.
// - Preheat enable bit: 1 turns preheat on, 0 off.
// - Torch bit 1 holds illumination at a fixed level, no modulation: permanently active, or permanently idle when polarity bit is 1.
// - Secondary output driven only when selected, else high-Z with termination.
module idc_illum_ctrl
    import idc_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_we,
    input  wire logic          reg_re,
    output logic      [DW-1:0] reg_rdata_q,
    output logic               reg_rvalid_q,
    input  wire logic          mod_in,
    output logic               primary_illum_oe_q,
    output logic               secondary_illum_out_q,
    output logic               secondary_illum_oe_q,
    output logic               secondary_term_en_q,
    output logic               preheat_en_q,
    output logic      [DW-1:0] seq_ctrl_q
);
    logic          hit_ctrl;
    logic          hit_seq;
    logic [DW-1:0] ctrl_q;
    logic [DW-1:0] seq_q;
    logic          invert;
    logic          primary_en;
    logic          second_en;
    logic          torch;
    logic          active;
    logic          level;

    assign hit_ctrl = (reg_addr == AW'(OFS_ILLUM_CTRL));
    assign hit_seq  = (reg_addr == AW'(OFS_SEQ_CTRL));

    idc_regs #(
        .DW (DW)
    ) u_regs (
        .clk     (clk),
        .srst    (srst),
        .wr_ctrl (reg_we && hit_ctrl),
        .wr_seq  (reg_we && hit_seq),
        .wdata   (reg_wdata),
        .ctrl_q  (ctrl_q),
        .seq_q   (seq_q)
    );

    assign invert     = ctrl_q[BIT_INVERT];
    assign primary_en = ctrl_q[BIT_PRIMARY_EN];
    assign second_en  = ctrl_q[BIT_SECOND_EN];
    assign torch      = ctrl_q[BIT_TORCH];

    // Torch overrides modulation before polarity, so inversion of a
    // torch-on output yields a permanently idle level
    assign active = torch ? 1'b1 : mod_in;
    assign level  = active ^ invert;

    // Read data registered; unmapped offsets answer zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_q  <= DW'(RDATA_UNMAPPED);
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_re;
            if (reg_re && hit_ctrl) begin
                reg_rdata_q <= ctrl_q;
            end else if (reg_re && hit_seq) begin
                reg_rdata_q <= seq_q;
            end else if (reg_re) begin
                reg_rdata_q <= DW'(RDATA_UNMAPPED);
            end
        end
    end

    // Open-drain primary pin: oe high means pin conductive
    always_ff @(posedge clk) begin
        if (srst) begin
            primary_illum_oe_q <= 1'b0;
        end else begin
            primary_illum_oe_q <= primary_en && level;
        end
    end

    // Push-pull secondary pin, terminated to io_ground when released
    always_ff @(posedge clk) begin
        if (srst) begin
            secondary_illum_out_q <= 1'b0;
            secondary_illum_oe_q  <= 1'b0;
            secondary_term_en_q   <= 1'b1;
        end else begin
            secondary_illum_oe_q  <= second_en;
            secondary_term_en_q   <= !second_en;
            secondary_illum_out_q <= second_en && level;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            preheat_en_q <= 1'b0;
            seq_ctrl_q   <= DW'(RST_SEQ_CTRL);
        end else begin
            preheat_en_q <= ctrl_q[BIT_PREHEAT];
            seq_ctrl_q   <= seq_q;
        end
    end

    chk_primary_disabled: assert property (
        @(posedge clk) disable iff (srst)
        !$past(primary_en) |-> !primary_illum_oe_q
    ) else $error("primary conducts while disabled");

    // Edge after reset still shows reset levels, so skip it
    chk_invert_idle: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(primary_en && invert && !torch && !mod_in)
        |-> primary_illum_oe_q
    ) else $error("inverted idle primary not conductive");

    chk_plain_idle: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(second_en && !invert && !torch && !mod_in)
        |-> secondary_illum_oe_q && !secondary_illum_out_q
    ) else $error("plain idle secondary not low");

    chk_plain_active: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(second_en && !invert && (torch || mod_in))
        |-> secondary_illum_oe_q && secondary_illum_out_q
    ) else $error("plain active secondary not high");

    chk_torch_hold: assert property (
        @(posedge clk) disable iff (srst)
        (primary_en && torch && !invert) [*3]
        |=> primary_illum_oe_q && $past(primary_illum_oe_q)
    ) else $error("torch did not hold primary on");

    chk_torch_invert: assert property (
        @(posedge clk) disable iff (srst)
        $past(primary_en && torch && invert)
        |-> !primary_illum_oe_q
    ) else $error("inverted torch primary not idle");

    chk_mod_follow: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(primary_en && !torch && !invert)
        |-> primary_illum_oe_q == $past(mod_in)
    ) else $error("primary does not follow modulation");

    chk_sec_release: assert property (
        @(posedge clk) disable iff (srst)
        $past(!second_en)
        |-> !secondary_illum_oe_q && secondary_term_en_q
            && !secondary_illum_out_q
    ) else $error("secondary driven while deselected");

    chk_sec_select: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(second_en)
        |-> secondary_illum_oe_q && !secondary_term_en_q
    ) else $error("secondary not driven while selected");

    chk_sec_inverted: assert property (
        @(posedge clk) disable iff (srst)
        !$past(srst) && $past(second_en && invert)
        |-> secondary_illum_out_q == !$past(active)
    ) else $error("secondary polarity wrong");

    chk_preheat_write: assert property (
        @(posedge clk) disable iff (srst)
        reg_we && hit_ctrl
        |=> ##1 preheat_en_q == $past(reg_wdata[BIT_PREHEAT], 2)
    ) else $error("preheat not taken from write");

    chk_enable_write: assert property (
        @(posedge clk) disable iff (srst)
        reg_we && hit_ctrl && !reg_wdata[BIT_PRIMARY_EN]
        ##1 !(reg_we && hit_ctrl)
        |=> !primary_illum_oe_q
    ) else $error("primary still on after disable write");

    chk_read_unmapped: assert property (
        @(posedge clk) disable iff (srst)
        reg_re && !hit_ctrl && !hit_seq
        |=> reg_rvalid_q && reg_rdata_q == DW'(RDATA_UNMAPPED)
    ) else $error("unmapped read not zero");

    chk_ctrl_readback: assert property (
        @(posedge clk) disable iff (srst)
        reg_re && hit_ctrl
        |=> reg_rvalid_q && reg_rdata_q == $past(ctrl_q)
    ) else $error("control readback wrong");

    chk_rvalid_pulse: assert property (
        @(posedge clk) disable iff (srst)
        reg_rvalid_q == ($past(reg_re) && !$past(srst))
    ) else $error("read valid not one cycle after strobe");

    cov_torch_on: cover property (
        @(posedge clk) disable iff (srst)
        torch && primary_en ##1 primary_illum_oe_q
    );

    cov_inverted_mod: cover property (
        @(posedge clk) disable iff (srst)
        primary_en && invert && !torch && mod_in
        ##1 !primary_illum_oe_q
    );

    cov_sec_released: cover property (
        @(posedge clk) disable iff (srst)
        secondary_illum_oe_q ##1 !secondary_illum_oe_q
    );

    cov_ctrl_readback: cover property (
        @(posedge clk) disable iff (srst)
        reg_we && hit_ctrl ##1 reg_re && hit_ctrl ##1 reg_rvalid_q
    );
endmodule

/* rtl/idc_pkg.sv */
package idc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets on the control port
    localparam logic [7:0] OFS_ILLUM_CTRL = 8'h90;
    localparam logic [7:0] OFS_SEQ_CTRL   = 8'h91;

    // Reset values
    localparam logic [7:0] RST_ILLUM_CTRL = 8'hC4;
    localparam logic [7:0] RST_SEQ_CTRL   = 8'h03;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // Field positions in illumination_driver_control
    localparam int unsigned BIT_INVERT     = 1;
    localparam int unsigned BIT_PRIMARY_EN = 2;
    localparam int unsigned BIT_PREHEAT    = 3;
    localparam int unsigned BIT_TORCH      = 4;
    localparam int unsigned BIT_SECOND_EN  = 5;
endpackage

/* rtl/idc_regs.sv */
module idc_regs
    import idc_pkg::*;
#(
    parameter int unsigned DW = DATA_W
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          wr_ctrl,
    input  wire logic          wr_seq,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] ctrl_q,
    output logic      [DW-1:0] seq_q
);
    // Reserved bits are stored as written and read back unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= DW'(RST_ILLUM_CTRL);
        end else if (wr_ctrl) begin
            ctrl_q <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_q <= DW'(RST_SEQ_CTRL);
        end else if (wr_seq) begin
            seq_q <= wdata;
        end
    end
endmodule

/* verif/idc_illum_load.sv */
module idc_illum_load (
    input  wire logic prim_oe,
    input  wire logic sec_out,
    input  wire logic sec_oe,
    input  wire logic sec_term,
    output logic      prim_pin,
    output logic      sec_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pull-up holds the open-drain pin high unless it conducts
    assign prim_pin = prim_oe ? 1'b0 : 1'b1;
    // Undriven, unterminated pin reads as the inverse of sec_out
    assign sec_pin = sec_oe ? sec_out : (sec_term ? 1'b0 : ~sec_out);
endmodule

/* verif/illumination_driver_control_tb.sv */
module illumination_driver_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import idc_pkg::*;
    logic       clk = 0, srst = 1, we = 0, re = 0, mod_in = 1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, seq;
    logic       rvalid, p_oe, s_out, s_oe, s_term, preheat, p_pin, s_pin;
    int         fails = 0, n_compared = 0, cyc = 0;
    idc_illum_ctrl DUT (.clk(clk), .srst(srst), .reg_addr(addr),
        .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .mod_in(mod_in), .primary_illum_oe_q(p_oe),
        .secondary_illum_out_q(s_out), .secondary_illum_oe_q(s_oe),
        .secondary_term_en_q(s_term), .preheat_en_q(preheat),
        .seq_ctrl_q(seq));
    idc_illum_load load (.prim_oe(p_oe), .sec_out(s_out), .sec_oe(s_oe),
        .sec_term(s_term), .prim_pin(p_pin), .sec_pin(s_pin));
    always #5 clk = ~clk;
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        wdata = d;
        we = 1;
        @(posedge clk) #1;
        we = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk) #1;
        addr = a;
        re = 1;
        @(posedge clk) #1;
        re = 0;
        chk("rvalid", 8'h01, rvalid);
        chk("rdata", exp, rdata);
    endtask
    task automatic t_reset();
        chk("primary_oe", 8'h01, p_oe);
        chk("seq_ctrl", RST_SEQ_CTRL, seq);
        chk("term_en", 8'h01, s_term);
        chk("rvalid", 8'h00, rvalid);
        rd(OFS_ILLUM_CTRL, RST_ILLUM_CTRL);
        rd(OFS_SEQ_CTRL, RST_SEQ_CTRL);
        rd(8'h55, RDATA_UNMAPPED);
    endtask
    task automatic t_midreset();
        @(posedge clk) #1;
        srst = 1;
        @(posedge clk) #1;
        chk("primary_oe", 8'h00, p_oe);
        chk("second_oe", 8'h00, s_oe);
        chk("second_out", 8'h00, s_out);
        chk("term_en", 8'h01, s_term);
        chk("preheat", 8'h00, preheat);
        chk("rdata", RDATA_UNMAPPED, rdata);
        chk("seq_ctrl", RST_SEQ_CTRL, seq);
        srst = 0;
        @(posedge clk) #1;
        chk("primary_oe", 8'h01, p_oe);
        chk("second_oe", 8'h00, s_oe);
        rd(OFS_ILLUM_CTRL, RST_ILLUM_CTRL);
    endtask
    task automatic t_regs();
        wr(OFS_SEQ_CTRL, 8'hA5);
        rd(OFS_SEQ_CTRL, 8'hA5);
        chk("seq_ctrl", 8'hA5, seq);
        wr(8'h92, 8'hFF);
        rd(OFS_ILLUM_CTRL, RST_ILLUM_CTRL);
        rd(8'h92, RDATA_UNMAPPED);
    endtask
    task automatic t_pins(logic [7:0] c);
        logic lvl;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk) #1;
            mod_in = m[0];
            wr(OFS_ILLUM_CTRL, c);
            @(posedge clk) #1;
            lvl = (c[BIT_TORCH] | m[0]) ^ c[BIT_INVERT];
            chk("primary_oe", c[BIT_PRIMARY_EN] & lvl, p_oe);
            chk("primary_pin", !(c[BIT_PRIMARY_EN] & lvl), p_pin);
            chk("second_oe", c[BIT_SECOND_EN], s_oe);
            chk("second_out", c[BIT_SECOND_EN] & lvl, s_out);
            chk("term_en", !c[BIT_SECOND_EN], s_term);
            chk("second_pin", c[BIT_SECOND_EN] & lvl, s_pin);
            chk("preheat", c[BIT_PREHEAT], preheat);
        end
        rd(OFS_ILLUM_CTRL, c);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 srst = 0;
        @(posedge clk) #1;
        t_reset();
        t_regs();
        t_pins(8'h00);
        t_pins(8'h04);
        t_pins(8'h06);
        t_pins(8'h14);
        t_pins(8'h16);
        t_pins(8'h20);
        t_pins(8'h2E);
        t_pins(8'hFC);
        t_midreset();
        t_pins(8'h08);
        summarize();
    end
endmodule
